// ### hw/ssw_map.svh
// Offsets, bit positions, reset values and timing counts of the supervisor
`ifndef SSW_MAP_SVH
`define SSW_MAP_SVH

// Clock rate in MHz and documented intervals in microseconds
`define SSW_CLK_MHZ 50
`define SSW_RST_SHORT_US 50000
`define SSW_RST_LONG_US 200000
`define SSW_WD_SHORT_US 100000
`define SSW_WD_LONG_US 1600000

// Interval lengths in external timebase clocks
`define SSW_EXT_WD_NORM 27'h0000400
`define SSW_EXT_WD_LONG 27'h0001000
`define SSW_EXT_RST_SHORT 27'h0000200
`define SSW_EXT_RST_LONG 27'h0000800

// Register byte offsets
`define SSW_CTRL_OFS 4'h0
`define SSW_STAT_OFS 4'h4

// Control register fields and reset value
`define SSW_CTRL_LONG_BIT 0
`define SSW_CTRL_RST 1'h0

// Status register fields
`define SSW_STAT_RST_BIT 0
`define SSW_STAT_FAULT_BIT 1
`define SSW_STAT_LONGTO_BIT 2
`define SSW_STAT_WDDIS_BIT 3
`define SSW_STAT_SUPLOW_BIT 4
`define SSW_STAT_EXTTB_BIT 5

// Pin vector positions and synchroniser reset values
`define SSW_NPINS 9
`define SSW_PIN_SUPLOW 0
`define SSW_PIN_BELOWBATT 1
`define SSW_PIN_PFLOW 2
`define SSW_PIN_CE 3
`define SSW_PIN_BATT 4
`define SSW_PIN_WDI 5
`define SSW_PIN_WDIMID 6
`define SSW_PIN_TBSEL 7
`define SSW_PIN_TBIN 8
`define SSW_PIN_RST 9'h0C9

`endif

// ### hw/ssw_pkg.sv
// Types shared by the supervisor design
package ssw_pkg;
  typedef logic [26:0] ssw_cnt_t;
  typedef enum logic [1:0] {
    SSW_RESP_OKAY = 2'h0,
    SSW_RESP_SLVERR = 2'h2
  } ssw_resp_t;
endpackage

// ### hw/ssw_supervisor.sv
// Supply supervisor with reset stretch, watchdog and AXI4-Lite registers
`timescale 1ns/1ps
`include "ssw_map.svh"

module ssw_supervisor
  import ssw_pkg::*;
#(
  parameter int unsigned RST_SHORT_CYC = `SSW_RST_SHORT_US * `SSW_CLK_MHZ,
  parameter int unsigned RST_LONG_CYC = `SSW_RST_LONG_US * `SSW_CLK_MHZ,
  parameter int unsigned WD_SHORT_CYC = `SSW_WD_SHORT_US * `SSW_CLK_MHZ,
  parameter int unsigned WD_LONG_CYC = `SSW_WD_LONG_US * `SSW_CLK_MHZ
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Comparator and switch results, all asynchronous
  input wire logic supply_below,
  input wire logic vcc_below_batt,
  input wire logic pf_below,
  input wire logic battery_switched,
  // Host pins
  input wire logic ce_in_n,
  input wire logic watchdog_toggle_in,
  input wire logic watchdog_toggle_mid,
  input wire logic timebase_select,
  input wire logic timebase_input,
  // Supervisor outputs
  output logic reset_n_out,
  output logic reset_out,
  output logic watchdog_fault_out,
  output logic powerfail_warn_out,
  output logic ce_out_n,
  output logic backup_active_out,
  output logic low_supply_n_out
);

  logic [`SSW_NPINS-1:0] pin_raw;
  logic [`SSW_NPINS-1:0] pin_q;
  logic sup_low;
  logic ext_mode;
  logic wd_dis;
  logic tb_prev;
  logic tick;
  logic wdi_prev;
  logic wdi_edge;
  logic reset_active;
  logic next_active;
  ssw_cnt_t rst_cnt;
  ssw_cnt_t next_rst_cnt;
  ssw_cnt_t rst_limit;
  ssw_cnt_t wd_cnt;
  ssw_cnt_t wd_limit;
  logic wd_run;
  logic wd_timeout;
  logic long_mode;
  logic ctrl_long;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic w_strb0_q;
  logic [31:0] stat_word;

  assign pin_raw = {timebase_input, timebase_select, watchdog_toggle_mid,
                    watchdog_toggle_in, battery_switched, ce_in_n,
                    pf_below, vcc_below_batt, supply_below};

  // Three-stage synchroniser; a new level counts once stages 2 and 3 agree
  for (genvar i = 0; i < `SSW_NPINS; i++) begin : g_sync
    localparam logic [`SSW_NPINS-1:0] RSTV = `SSW_PIN_RST;
    logic st1;
    logic st2;
    logic st3;
    logic q;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        st1 <= RSTV[i];
        st2 <= RSTV[i];
        st3 <= RSTV[i];
        q <= RSTV[i];
      end else begin
        st1 <= pin_raw[i];
        st2 <= st1;
        st3 <= st2;
        if (st2 == st3) begin
          q <= st3;
        end
      end
    end
    assign pin_q[i] = q;
  end

  assign sup_low = pin_q[`SSW_PIN_SUPLOW];
  assign ext_mode = ~pin_q[`SSW_PIN_TBSEL];
  assign wd_dis = pin_q[`SSW_PIN_WDIMID];

  // Timebase tick: every clock internally, rising edge of external source
  assign tick = ext_mode ? (pin_q[`SSW_PIN_TBIN] & ~tb_prev) : 1'b1;

  // Interval limits by mode, variant and timebase input level
  always_comb begin
    if (ext_mode) begin
      rst_limit = ctrl_long ? `SSW_EXT_RST_LONG : `SSW_EXT_RST_SHORT;
      wd_limit = long_mode ? `SSW_EXT_WD_LONG : `SSW_EXT_WD_NORM;
    end else begin
      rst_limit = ctrl_long ? 27'(RST_LONG_CYC) : 27'(RST_SHORT_CYC);
      if (long_mode || pin_q[`SSW_PIN_TBIN]) begin
        wd_limit = 27'(WD_LONG_CYC);
      end else begin
        wd_limit = 27'(WD_SHORT_CYC);
      end
    end
  end

  // Edge memories for the timebase and the toggle input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb_prev <= 1'b0;
      wdi_prev <= 1'b0;
    end else begin
      tb_prev <= pin_q[`SSW_PIN_TBIN];
      wdi_prev <= pin_q[`SSW_PIN_WDI];
    end
  end

  // Mid level masks edges so a floating input cannot feed the timer
  assign wdi_edge = ~wd_dis & (pin_q[`SSW_PIN_WDI] != wdi_prev);
  assign wd_run = ~wd_dis & ~reset_active & ~sup_low;
  assign wd_timeout = wd_run & tick & ~wdi_edge &
                      (wd_cnt >= wd_limit - 27'h1);

  // Reset stretch: low supply holds it, timeout or supply return starts it
  always_comb begin
    next_active = reset_active;
    next_rst_cnt = rst_cnt;
    if (sup_low) begin
      next_active = 1'b1;
      next_rst_cnt = '0;
    end else if (wd_timeout) begin
      next_active = 1'b1;
      next_rst_cnt = '0;
    end else if (reset_active && tick) begin
      if (rst_cnt >= rst_limit - 27'h1) begin
        next_active = 1'b0;
        next_rst_cnt = '0;
      end else begin
        next_rst_cnt = rst_cnt + 27'h1;
      end
    end
  end

  // Both reset pins from one next value so they never disagree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_active <= 1'b1;
      rst_cnt <= '0;
      reset_n_out <= 1'b0;
      reset_out <= 1'b1;
    end else begin
      reset_active <= next_active;
      rst_cnt <= next_rst_cnt;
      reset_n_out <= ~next_active;
      reset_out <= next_active;
    end
  end

  // Watchdog count; held at zero during reset so it restarts at its end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_cnt <= '0;
    end else if (!wd_run || wdi_edge) begin
      wd_cnt <= '0;
    end else if (tick) begin
      wd_cnt <= wd_timeout ? '0 : wd_cnt + 27'h1;
    end
  end

  // Long timeout armed by any reset, dropped by first toggle afterwards
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      long_mode <= 1'b1;
    end else if (reset_active || sup_low) begin
      long_mode <= 1'b1;
    end else if (wdi_edge) begin
      long_mode <= 1'b0;
    end
  end

  // Fault output; disable and low supply outrank a timeout
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_fault_out <= 1'b1;
    end else if (wd_dis) begin
      watchdog_fault_out <= 1'b1;
    end else if (sup_low) begin
      watchdog_fault_out <= 1'b1;
    end else if (wd_timeout) begin
      watchdog_fault_out <= 1'b0;
    end else if (wdi_edge) begin
      watchdog_fault_out <= 1'b1;
    end
  end

  // Supply status pins; no stretch on the low-supply flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      powerfail_warn_out <= 1'b0;
      ce_out_n <= 1'b1;
      backup_active_out <= 1'b0;
      low_supply_n_out <= 1'b0;
    end else begin
      powerfail_warn_out <= ~(pin_q[`SSW_PIN_PFLOW] |
                              pin_q[`SSW_PIN_BELOWBATT]);
      ce_out_n <= sup_low | pin_q[`SSW_PIN_CE];
      backup_active_out <= pin_q[`SSW_PIN_BATT];
      low_supply_n_out <= ~sup_low;
    end
  end

  // Status word shows the supervisor's live state
  always_comb begin
    stat_word = '0;
    stat_word[`SSW_STAT_RST_BIT] = reset_active;
    stat_word[`SSW_STAT_FAULT_BIT] = ~watchdog_fault_out;
    stat_word[`SSW_STAT_LONGTO_BIT] = long_mode;
    stat_word[`SSW_STAT_WDDIS_BIT] = wd_dis;
    stat_word[`SSW_STAT_SUPLOW_BIT] = sup_low;
    stat_word[`SSW_STAT_EXTTB_BIT] = ext_mode;
  end

  // Write side: address and data latched in either order, then answered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0;
      w_strb0_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= SSW_RESP_OKAY;
      ctrl_long <= `SSW_CTRL_RST;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        awready <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wready <= 1'b0;
        w_data_q <= wdata;
        w_strb0_q <= wstrb[0];
      end
      if (aw_held && w_held && !bvalid) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= SSW_RESP_OKAY;
        if ({aw_addr_q[3:2], 2'h0} == `SSW_CTRL_OFS) begin
          if (w_strb0_q) begin
            ctrl_long <= w_data_q[`SSW_CTRL_LONG_BIT];
          end
        end else if ({aw_addr_q[3:2], 2'h0} != `SSW_STAT_OFS) begin
          bresp <= SSW_RESP_SLVERR; // Unmapped word
        end
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read side: one read at a time, answered the cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= SSW_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= SSW_RESP_OKAY;
      if ({araddr[3:2], 2'h0} == `SSW_CTRL_OFS) begin
        rdata <= {31'h0, ctrl_long};
      end else if ({araddr[3:2], 2'h0} == `SSW_STAT_OFS) begin
        rdata <= stat_word;
      end else begin
        rdata <= 32'h0;
        rresp <= SSW_RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Checks on the supervisor behaviour
  sequence toggle_after_reset_s;
    wdi_edge && !reset_active && !sup_low;
  endsequence

  sequence timeout_s;
    wd_timeout;
  endsequence

  reset_pair_a: assert property (
    @(posedge aclk) disable iff (!aresetn) reset_out == !reset_n_out)
    else $error("reset outputs not complementary");

  supply_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn) sup_low |=> !reset_n_out [*1]
      ##0 ce_out_n && !low_supply_n_out)
    else $error("low supply did not hold reset and gates");

  flag_return_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
      $fell(sup_low) |=> low_supply_n_out && !reset_n_out)
    else $error("low supply flag not immediate or reset not stretched");

  timeout_reset_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
      timeout_s |=> (!reset_n_out && !watchdog_fault_out) ##1 long_mode)
    else $error("timeout did not pulse reset and fault");

  toggle_restart_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
      wdi_edge |=> wd_cnt == 27'h0)
    else $error("toggle did not restart watchdog count");

  disabled_quiet_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
      wd_dis |=> watchdog_fault_out && !wd_timeout)
    else $error("disabled watchdog acted");

  normal_timeout_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
      toggle_after_reset_s |=> !long_mode)
    else $error("first toggle did not end long timeout");

  powerfail_out_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
      (pin_q[`SSW_PIN_PFLOW] || pin_q[`SSW_PIN_BELOWBATT])
      |=> !powerfail_warn_out)
    else $error("power-fail warning not low");

  backup_follow_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
      ##1 backup_active_out == $past(pin_q[`SSW_PIN_BATT]))
    else $error("backup flag does not follow switch");

endmodule

// ### sim/ssw_host_model.sv
// Host processor model: watchdog servicing and external timebase
`timescale 1ns/1ps

module ssw_host_model #(
  parameter int GAP = 30,
  parameter int TB_HALF = 4
) (
  // Clock and reset seen by the host
  input wire logic aclk,
  input wire logic reset_n_out,
  // Bench controls
  input wire logic run,
  input wire logic kick,
  input wire logic mid,
  input wire logic ext,
  input wire logic tb_level,
  // Pins towards the supervisor
  output logic watchdog_toggle_in,
  output logic watchdog_toggle_mid,
  output logic timebase_input
);
  int cnt = 0;
  int tbc = 0;
  logic tb_clk = 1'b0;
  logic wdi_lvl = 1'b0;

  // Host services only while out of reset; mid leaves the level wandering
  always @(posedge aclk) begin
    if (mid || kick || (run && reset_n_out && cnt == GAP - 1)) begin
      wdi_lvl <= ~wdi_lvl;
      cnt <= 0;
    end else begin
      cnt <= (run && reset_n_out) ? cnt + 1 : 0;
    end
  end

  assign watchdog_toggle_in = wdi_lvl;

  // Free-running external timebase clock
  always @(posedge aclk) begin
    tbc <= (tbc == TB_HALF - 1) ? 0 : tbc + 1;
    if (tbc == TB_HALF - 1) begin
      tb_clk <= ~tb_clk;
    end
  end

  assign watchdog_toggle_mid = mid;
  // Clock in external mode, timeout select level otherwise
  assign timebase_input = ext ? tb_clk : tb_level;
endmodule

// ### sim/ssw_supervisor_bench.sv
// Self-checking bench for the supply supervisor
`timescale 1ns/1ps
`include "ssw_map.svh"

module ssw_supervisor_bench import ssw_pkg::*; ;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr, araddr, wstrb;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic supply_below, vcc_below_batt, pf_below, battery_switched;
  logic ce_in_n, timebase_select, run, kick, mid, ext, tb_level;
  logic wd_in, wd_mid, tb_in;
  logic reset_n_out, reset_out, watchdog_fault_out, powerfail_warn_out;
  logic ce_out_n, backup_active_out, low_supply_n_out;
  int bad_count = 0;
  int checks = 0;

  ssw_supervisor #(.RST_SHORT_CYC(20), .RST_LONG_CYC(40),
    .WD_SHORT_CYC(60), .WD_LONG_CYC(200)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .supply_below(supply_below),
    .vcc_below_batt(vcc_below_batt), .pf_below(pf_below),
    .battery_switched(battery_switched), .ce_in_n(ce_in_n),
    .watchdog_toggle_in(wd_in), .watchdog_toggle_mid(wd_mid),
    .timebase_select(timebase_select), .timebase_input(tb_in),
    .reset_n_out(reset_n_out), .reset_out(reset_out),
    .watchdog_fault_out(watchdog_fault_out),
    .powerfail_warn_out(powerfail_warn_out), .ce_out_n(ce_out_n),
    .backup_active_out(backup_active_out),
    .low_supply_n_out(low_supply_n_out));

  ssw_host_model u_host (.aclk(aclk), .reset_n_out(reset_n_out),
    .run(run), .kick(kick), .mid(mid), .ext(ext), .tb_level(tb_level),
    .watchdog_toggle_in(wd_in), .watchdog_toggle_mid(wd_mid),
    .timebase_input(tb_in));

  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // Count cycles until the active-low reset reaches v
  task wait_rst(input logic v, input int mx, output int n);
    n = 0;
    while (reset_n_out !== v && n < mx) begin
      @(negedge aclk);
      n++;
    end
  endtask

  // Register write; address and data released as each is taken
  task axw(input logic [3:0] a, input logic [31:0] dv);
    @(posedge aclk);
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    r = 2'h3;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'b0;
  endtask

  task axr(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r = 2'h3;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        r = rresp;
        d = rdata;
        break;
      end
    end
    rready <= 1'b0;
  endtask

  // Supply dip then return; stretch measured from the return
  task t_supply(input int lo, input int hi);
    int n;
    @(posedge aclk);
    supply_below <= 1'b1;
    ce_in_n <= 1'b0;
    cyc(7);
    @(negedge aclk);
    chk(reset_n_out === 1'b0 && reset_out === 1'b1, "reset low");
    chk(low_supply_n_out === 1'b0, "low flag");
    chk(ce_out_n === 1'b1, "ce gated");
    chk(watchdog_fault_out === 1'b1, "fault high");
    @(posedge aclk);
    supply_below <= 1'b0;
    cyc(7);
    @(negedge aclk);
    chk(low_supply_n_out === 1'b1 && reset_n_out === 1'b0, "flag");
    wait_rst(1'b1, hi, n);
    chk(n + 8 >= lo && n + 8 <= hi, "stretch length");
  endtask

  task t_pins;
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      pf_below <= i[0];
      vcc_below_batt <= i[1];
      battery_switched <= i[1];
      ce_in_n <= i[0];
      cyc(7);
      @(negedge aclk);
      chk(powerfail_warn_out === (i == 0), "warn");
      chk(backup_active_out === i[1], "backup");
      chk(ce_out_n === i[0], "ce pass");
    end
    @(posedge aclk);
    pf_below <= 1'b0;
    vcc_below_batt <= 1'b0;
    battery_switched <= 1'b0;
    $display("pins test done");
  endtask

  task t_regs;
    axr(`SSW_CTRL_OFS);
    chk(d === 32'h0 && r === SSW_RESP_OKAY, "ctrl reset");
    axw(`SSW_CTRL_OFS, 32'h1);
    chk(r === SSW_RESP_OKAY, "ctrl write");
    axr(`SSW_CTRL_OFS);
    chk(d === 32'h1, "ctrl read");
    // Byte 0 masked off: the variant bit must keep its value
    wstrb <= 4'hE;
    {awprot, arprot} <= 6'h12;
    axw(`SSW_CTRL_OFS, 32'h0);
    chk(r === SSW_RESP_OKAY, "masked write");
    axr(`SSW_CTRL_OFS);
    chk(d === 32'h1, "masked byte kept");
    wstrb <= 4'hF;
    axr(4'h8);
    chk(r === SSW_RESP_SLVERR && d === 32'h0, "unmapped read");
    axw(4'hC, 32'h1);
    chk(r === SSW_RESP_SLVERR, "unmapped write");
    axr(`SSW_STAT_OFS);
    chk(d[`SSW_STAT_WDDIS_BIT] === 1'b1, "disabled bit");
    t_supply(40, 52);
    axw(`SSW_CTRL_OFS, 32'h0);
    $display("register test done");
  endtask

  // Toggle, then measure the timeout length, the reset pulse width and the fault level
  task t_timeout(input int lo, input int hi);
    int n;
    @(posedge aclk);
    kick <= 1'b1;
    @(posedge aclk);
    kick <= 1'b0;
    cyc(7);
    @(negedge aclk);
    chk(watchdog_fault_out === 1'b1, "fault cleared");
    wait_rst(1'b0, hi, n);
    chk(n + 9 >= lo && n + 9 <= hi, "timeout length");
    wait_rst(1'b1, 40, n);
    chk(n >= 19 && n <= 22, "pulse width");
    chk(watchdog_fault_out === 1'b0, "fault low");
  endtask

  // Reset and fault must stay high for 600 cycles
  task t_quiet(input string m);
    int lows;
    lows = 0;
    repeat (600) begin
      @(negedge aclk);
      if (reset_n_out !== 1'b1 || watchdog_fault_out !== 1'b1) lows++;
    end
    chk(lows == 0, m);
  endtask

  task t_wd;
    int n;
    @(posedge aclk);
    mid <= 1'b0;
    t_supply(20, 32);
    wait_rst(1'b0, 260, n);
    chk(n >= 199 && n <= 206, "long after reset");
    wait_rst(1'b1, 40, n);
    chk(n >= 19 && n <= 22, "pulse width");
    t_timeout(58, 72);
    @(posedge aclk);
    tb_level <= 1'b1;
    t_timeout(198, 212);
    t_supply(20, 32);
    @(posedge aclk);
    run <= 1'b1;
    t_quiet("serviced");
    @(posedge aclk);
    run <= 1'b0;
    mid <= 1'b1;
    t_quiet("disabled");
    $display("watchdog test done");
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = {8'h00, 32'h0, 4'hF};
    {awprot, arprot} = 6'h00;
    {supply_below, vcc_below_batt, pf_below, battery_switched} = 4'h0;
    {ce_in_n, timebase_select, run, kick} = 4'hC;
    {mid, ext, tb_level} = 3'h4;
    cyc(5);
    aresetn <= 1'b1;
    t_supply(20, 60);
    $display("supply test done");
    t_pins;
    t_regs;
    t_wd;
    @(posedge aclk);
    timebase_select <= 1'b0;
    ext <= 1'b1;
    t_supply(4088, 4124);
    $display("external timebase test done");
    final_report;
  end

  // Hang guard
  initial begin
    #(20 * 30000);
    bad_count++;
    $display("wrong value at %0t: run timed out", $time);
    final_report;
  end

  task final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
endmodule
